// ===== dv/ers_consumer_model.sv
// Consumer model: DMA engine servicing requests, CPU core acking levels.
// Assumes the router's outputs on the same clock; slow adds idle cycles.
`default_nettype none
module ers_consumer_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        serve,
  input  wire logic [1:0]  slow,
  input  wire logic [63:0] req,
  input  wire logic        cval,
  input  wire logic [3:0]  clvl,
  output logic      [63:0] svc,
  output logic      [15:0] ack
);
  logic [1:0] wait_cnt;
  // Serve one request and ack one level, then pause so state can settle
  always_ff @(posedge clk) begin
    svc <= 64'h0;
    ack <= 16'h0;
    if (!rst_n || !serve || svc != 64'h0 || ack != 16'h0) wait_cnt <= slow;
    else if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
    else begin
      svc <= req & (~req + 64'h1);
      ack <= cval ? 16'h1 << clvl : 16'h0;
    end
  end
endmodule
`default_nettype wire

// ===== dv/ers_router_monitor.sv
// Checker for the event router: bus timing, request hold and CPU levels.
// Assumes it is bound to ers_router and sees only that module's ports.
`default_nettype none
module ers_router_monitor (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [63:0] CHAIN_EVENT,
  input wire logic [63:0] DMA_SERVICED,
  input wire logic [63:0] DMA_REQUEST,
  input wire logic [3:0]  FIXED_IRQ,
  input wire logic [15:0] CPU_ACK,
  input wire logic [15:0] CPU_IRQ,
  input wire logic        CPU_IRQ_VALID,
  input wire logic [3:0]  CPU_IRQ_LEVEL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Bus steps: setup taken, then a one-cycle answer
  sequence setup_s;
    PSEL && !PENABLE && CE;
  endsequence
  sequence answer_s;
    PREADY ##1 !PREADY;
  endsequence
  ready_once_a: assert property (setup_s |=> answer_s)
    else $error("ready not one cycle after setup");
  bad_addr_a: assert property (PSEL && !PENABLE && CE && PADDR == 32'h019C_0030 |=>
    PREADY && PSLVERR && (PWRITE || PRDATA == 32'h0)) else $error("unmapped access not refused");
  req_holds_a: assert property (DMA_REQUEST[1] && !DMA_SERVICED[1] && !(PSEL && PWRITE) |=>
    DMA_REQUEST[1]) else $error("request dropped without service");
  free_chan_a: assert property ($rose(DMA_REQUEST[21]) |->
    $past(CHAIN_EVENT[21]) || $past(PSEL && PWRITE)) else $error("free channel raised by itself");
  lowest_lvl_a: assert property (CPU_IRQ_VALID |-> CPU_IRQ[CPU_IRQ_LEVEL] &&
    (CPU_IRQ & ((16'h1 << CPU_IRQ_LEVEL) - 16'h1)) == 16'h0) else $error("level not lowest pending");
  valid_any_a: assert property (CPU_IRQ_VALID == (CPU_IRQ != 16'h0))
    else $error("valid disagrees with levels");
  fixed_lvl_a: assert property (CE && FIXED_IRQ[1] |=> CPU_IRQ[1])
    else $error("fixed level not raised");
  lvl_holds_a: assert property (CPU_IRQ[2] && !CPU_ACK[2] |=> CPU_IRQ[2])
    else $error("fixed level dropped without ack");
endmodule
bind ers_router ers_router_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CHAIN_EVENT(CHAIN_EVENT), .DMA_SERVICED(DMA_SERVICED), .DMA_REQUEST(DMA_REQUEST), .FIXED_IRQ(FIXED_IRQ),
  .CPU_ACK(CPU_ACK), .CPU_IRQ(CPU_IRQ), .CPU_IRQ_VALID(CPU_IRQ_VALID), .CPU_IRQ_LEVEL(CPU_IRQ_LEVEL));
`default_nettype wire

// ===== dv/tb.sv
// Testbench: registers over APB, channel map, service and status interrupt,
// CPU level selection. Assumes ers_router, its monitor and the consumer model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ers_pkg::*;
  logic        clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, serve = 0;
  logic        pready, pslverr, irq, cval;
  logic [31:0] paddr = 0, pwdata = 0, prdata, sel, src = 0, s;
  logic [33:0] evv = 0;
  logic [63:0] chain = 0, svc, req, exp;
  logic [15:0] ack, cirq, e16;
  logic [3:0]  fix = 0, clvl, f, lo;
  logic [1:0]  slow = 0;
  logic [32:0] q[$];
  int          n_fail = 0, check_count = 0, cyc = 0;
  int          fpos[6] = '{SEL_F0, SEL_F1, SEL_F2, SEL_F3, SEL_F4, SEL_F5};
  int          chmap[38] = '{0, 1, 2, 19, 3, 20, 8, 9, 10, 11, 4, 5, 6, 7, 48, 49, 50, 51, 52, 53, 54, 55,
                             12, 14, 17, 13, 15, 18, 28, 29, 30, 31, 32, 40, 16, 21, 63, 0};
  ers_router uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HOST_EVENT(evv[0]), .TIMER_EVENT(evv[3:1]), .SDRAM_EVENT(evv[5:4]), .PIN_EVENT(evv[21:6]),
    .SERIAL_TX_EVENT(evv[24:22]), .SERIAL_RX_EVENT(evv[27:25]), .CONV_EVENT(evv[29:28]),
    .TURBO_EVENT(evv[31:30]), .CELL_EVENT(evv[33:32]), .CHAIN_EVENT(chain), .DMA_SERVICED(svc),
    .DMA_REQUEST(req), .IRQ_SOURCE(src), .FIXED_IRQ(fix), .CPU_ACK(ack), .CPU_IRQ(cirq),
    .CPU_IRQ_VALID(cval), .CPU_IRQ_LEVEL(clvl), .IRQ(irq));
  ers_consumer_model u_model (.clk(clk), .rst_n(rst_n), .serve(serve), .slow(slow), .req(req), .cval(cval),
    .clvl(clvl), .svc(svc), .ack(ack));
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [63:0] seen, exp_v);
    check_count++;
    if (seen !== exp_v) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp_v, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input bit w, input logic [31:0] a, d, input logic [32:0] e);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk("pready_wait", n, 1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    apb(0, a, 0, e);
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1, a, d, 0);
  endtask
  task automatic pulse(input logic [33:0] v, input logic [63:0] c, input logic [31:0] sv, input logic [3:0] fv);
    @(posedge clk);
    evv <= v;
    chain <= c;
    src <= sv;
    fix <= fv;
    @(posedge clk);
    evv <= 0;
    chain <= 0;
    src <= 0;
    fix <= 0;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      complete_run();
    end
  end
  // Compare each read answer with the oldest note
  always @(posedge clk)
    if (psel && penable && pready && !pwrite) chk("prdata", {pslverr, prdata}, q.pop_front());
  initial begin
    s = $urandom(6838);
    slow = 2'($urandom_range(3));
    chmap[37] = $urandom_range(63);
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(ADDR_SEL_HIGH, {1'b0, SEL_HIGH_RST});
    rd(ADDR_CPU_EN, 33'hF);
    rd(32'h019C_0030, {1'b1, ZERO32});
    wr(32'h019C_0030, 32'hFFFF_FFFF);
    // Each source and four chain triggers set exactly their own pending bit
    for (int k = 0; k < 38; k++) begin
      if (k < 34) pulse(34'(1) << k, 0, 0, 0);
      else pulse(0, 64'(1) << chmap[k], 0, 0);
      exp = 64'(1) << chmap[k];
      rd(ADDR_PEND_LOW, {1'b0, exp[31:0]});
      rd(ADDR_PEND_HIGH, {1'b0, exp[63:32]});
      wr(ADDR_PEND_LOW, 32'hFFFF_FFFF);
      wr(ADDR_PEND_HIGH, 32'hFFFF_FFFF);
    end
    $display("test channel map done");
    // Clock enable low freezes capture: a pulse then must leave nothing
    @(posedge clk);
    ce <= 0;
    pulse(34'h1, 0, 0, 0);
    @(posedge clk);
    ce <= 1;
    rd(ADDR_PEND_LOW, {1'b0, ZERO32});
    $display("test clock enable done");
    rd(ADDR_IRQ_STAT, 33'h2);
    wr(ADDR_EN_LOW, 32'h0020_0002);
    wr(ADDR_IRQ_MASK, 32'h3);
    pulse(34'h2, 64'h0020_0000, 0, 0);
    @(negedge clk);
    chk("dma_request", req, 64'h0020_0002);
    pulse(34'h2, 0, 0, 0);
    repeat (3) @(negedge clk);
    chk("dma_request", req, 64'h0020_0002);
    chk("irq", irq, 1);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(negedge clk);
    chk("irq", irq, 0);
    wr(ADDR_IRQ_MASK, 32'h1);
    rd(ADDR_IRQ_STAT, 33'h1);
    repeat (2) @(negedge clk);
    chk("irq", irq, 0);
    @(posedge clk);
    serve <= 1;
    for (int n = 0; n < 50 && req !== 0; n++) @(posedge clk);
    serve <= 0;
    rd(ADDR_PEND_LOW, 33'h0);
    $display("test dma service done");
    // Random selector codes, masked then enabled levels, then acked
    for (int it = 0; it < 3; it++) begin
      sel = 32'h8000_8000;
      for (int i = 0; i < 6; i++) sel[fpos[i] +: 5] = 5'($urandom_range(20));
      wr(ADDR_SEL_LOW, sel);
      rd(ADDR_SEL_LOW, {1'b0, sel & 32'h7FFF_7FFF});
      wr(ADDR_CPU_EN, 32'h0);
      s = $urandom;
      f = 4'($urandom) | 4'h6;
      pulse(0, 0, s, f);
      exp = {SEL_HIGH_RST, sel};
      e16 = {12'h0, f};
      for (int l = 0; l < 12; l++) e16[l + 4] = s[exp[fpos[l % 6] + 32 * (l / 6) +: 5]];
      repeat (2) @(negedge clk);
      chk("cpu_irq", cirq, e16 & 16'h000F);
      wr(ADDR_CPU_EN, 32'h0000_FFF0);
      repeat (2) @(negedge clk);
      chk("cpu_irq", cirq, e16);
      for (int l = 15; l >= 0; l--) if (e16[l]) lo = 4'(l);
      chk("cpu_level", clvl, lo);
      @(posedge clk);
      serve <= 1;
      for (int n = 0; n < 200 && cirq !== 0; n++) @(posedge clk);
      serve <= 0;
      chk("cpu_irq", cirq, 0);
      $display("test cpu levels done");
    end
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(ADDR_SEL_LOW, {1'b0, SEL_LOW_RST});
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire

// ===== hdl/ers_pkg.sv
// Package for the event routing and interrupt selector block.
// Assumes a single system clock; offsets are APB byte addresses.
`default_nettype none
package ers_pkg;
  localparam int          ERS_CHANNELS   = 64;
  localparam int          ERS_LEVELS     = 16;
  localparam int          ERS_SEL_W      = 5;
  localparam int          ERS_NUM_SRC    = 32;
  localparam int          ERS_FIRST_MASK = 4;
  // Register byte addresses
  localparam logic [31:0] ADDR_SEL_HIGH  = 32'h019C_0000;
  localparam logic [31:0] ADDR_SEL_LOW   = 32'h019C_0004;
  localparam logic [31:0] ADDR_PEND_LOW  = 32'h019C_0010;
  localparam logic [31:0] ADDR_PEND_HIGH = 32'h019C_0014;
  localparam logic [31:0] ADDR_EN_LOW    = 32'h019C_0018;
  localparam logic [31:0] ADDR_EN_HIGH   = 32'h019C_001C;
  localparam logic [31:0] ADDR_IRQ_STAT  = 32'h019C_0020;
  localparam logic [31:0] ADDR_IRQ_MASK  = 32'h019C_0024;
  localparam logic [31:0] ADDR_CPU_EN    = 32'h019C_0028;
  localparam logic [31:0] ADDR_CPU_PEND  = 32'h019C_002C;
  // Selector field positions (low bit of each of six fields)
  localparam int          SEL_F0 = 0;
  localparam int          SEL_F1 = 5;
  localparam int          SEL_F2 = 10;
  localparam int          SEL_F3 = 16;
  localparam int          SEL_F4 = 21;
  localparam int          SEL_F5 = 26;
  // Reset values: low holds levels 4..9, high holds levels 10..15
  localparam logic [31:0] SEL_LOW_RST  = {1'b0, 5'b01001, 5'b01000, 5'b00111, 1'b0, 5'b00110, 5'b00101, 5'b00100};
  localparam logic [31:0] SEL_HIGH_RST = {1'b0, 5'b00010, 5'b00001, 5'b00000, 1'b0, 5'b01011, 5'b01010, 5'b00011};
  localparam logic [31:0] ZERO32       = 32'h0000_0000;
  // Fixed channel numbers with a source
  localparam int CH_HOST = 0;
  localparam int CH_TMR0 = 1;
  localparam int CH_TMR1 = 2;
  localparam int CH_SDA  = 3;
  localparam int CH_PIN4 = 4;
  localparam int CH_PIN0 = 8;
  localparam int CH_SER0 = 12;
  localparam int CH_SER2 = 17;
  localparam int CH_TMR2 = 19;
  localparam int CH_SDB  = 20;
  localparam int CH_CONV = 28;
  localparam int CH_TURB = 30;
  localparam int CH_CRX  = 32;
  localparam int CH_CTX  = 40;
  localparam int CH_PIN8 = 48;
  // Interrupt status bits
  localparam int IRQ_ENG_OVR  = 0;
  localparam int IRQ_NEW_EVT  = 1;
  localparam int IRQ_W        = 2;
  typedef enum logic [1:0] {ERS_IDLE, ERS_ACCESS} ers_bus_e;
endpackage
`default_nettype wire

// ===== hdl/ers_router.sv
// Event router: 64 fixed DMA sync channels plus 16-level CPU interrupt selector.
// Assumes synchronous single-cycle event pulses and an APB master on CLK.
//
// Contract
// [RULE1] Sixty-four channels, each fixed source
// [RULE2] Events latch pending even when disabled
// [RULE3] Priority comes from parameters, not channel
// [RULE4] Channels 0-3: host, timer0, timer1, sdram
// [RULE5] Pin events to channels 4-11, 48-55
// [RULE6] Serial ports, timer2, second sdram mapped
// [RULE7] Reserved and unconnected channels stay idle
// [RULE8] Decoder channels 28-31, reserved if absent
// [RULE9] Cell interface channels 32, 40
// [RULE10] Chain completion can trigger any channel
// [RULE11] Sixteen levels, zero highest priority
// [RULE12] Levels 0-3 fixed, non-maskable
// [RULE13] Levels 4-15 selected through two registers
// [RULE14] Five-bit fields, documented reset defaults
// [RULE15] Software avoids reserved selector codes
// [RULE16] Pending holds until serviced or cleared
// [RULE17] Lowest-numbered pending level presented first
`default_nettype none
module ers_router
  import ers_pkg::*;
#(
  parameter bit HAS_DECODERS = 1'b1,
  parameter bit HAS_CELL_IF  = 1'b1
) (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic                       CE,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [31:0]                PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  input  wire logic                       HOST_EVENT,
  input  wire logic [2:0]                 TIMER_EVENT,
  input  wire logic [1:0]                 SDRAM_EVENT,
  input  wire logic [15:0]                PIN_EVENT,
  input  wire logic [2:0]                 SERIAL_TX_EVENT,
  input  wire logic [2:0]                 SERIAL_RX_EVENT,
  input  wire logic [1:0]                 CONV_EVENT,
  input  wire logic [1:0]                 TURBO_EVENT,
  input  wire logic [1:0]                 CELL_EVENT,
  input  wire logic [ERS_CHANNELS-1:0]    CHAIN_EVENT,
  input  wire logic [ERS_CHANNELS-1:0]    DMA_SERVICED,
  output logic      [ERS_CHANNELS-1:0]    DMA_REQUEST,
  input  wire logic [ERS_NUM_SRC-1:0]     IRQ_SOURCE,
  input  wire logic [3:0]                 FIXED_IRQ,
  input  wire logic [ERS_LEVELS-1:0]      CPU_ACK,
  output logic      [ERS_LEVELS-1:0]      CPU_IRQ,
  output logic                            CPU_IRQ_VALID,
  output logic      [3:0]                 CPU_IRQ_LEVEL,
  output logic                            IRQ
);
  import ers_pkg::*;

  typedef struct packed {
    logic [31:0]              sel_high;
    logic [31:0]              sel_low;
    logic [ERS_CHANNELS-1:0]  pend;
    logic [ERS_CHANNELS-1:0]  en;
    logic [ERS_LEVELS-1:0]    cpu_pend;
    logic [ERS_LEVELS-1:0]    cpu_en;
    logic [IRQ_W-1:0]         irq_stat;
    logic [IRQ_W-1:0]         irq_mask;
    logic [31:0]              rdata;
    logic                     slverr;
    ers_bus_e                 bus;
  } ers_state_s;

  ers_state_s               st;
  ers_state_s               next_st;
  logic [ERS_CHANNELS-1:0]  evt;
  logic [ERS_LEVELS-1:0]    lvl_src;
  logic [ERS_SEL_W-1:0]     sel [ERS_LEVELS];
  logic                     wr_acc;
  logic                     rd_acc;

  // Fixed channel map, no software reassignment
  always_comb begin
    evt                      = '0;                                   // [RULE7]
    evt[CH_HOST]             = HOST_EVENT;                           // [RULE4]
    evt[CH_TMR0]             = TIMER_EVENT[0];                       // [RULE4]
    evt[CH_TMR1]             = TIMER_EVENT[1];                       // [RULE4]
    evt[CH_SDA]              = SDRAM_EVENT[0];                       // [RULE4]
    evt[CH_PIN4 +: 4]        = PIN_EVENT[7:4];                       // [RULE5]
    evt[CH_PIN0 +: 4]        = PIN_EVENT[3:0];                       // [RULE5]
    evt[CH_PIN8 +: 8]        = PIN_EVENT[15:8];                      // [RULE5]
    evt[CH_SER0]             = SERIAL_TX_EVENT[0];                   // [RULE6]
    evt[CH_SER0 + 1]         = SERIAL_RX_EVENT[0];                   // [RULE6]
    evt[CH_SER0 + 2]         = SERIAL_TX_EVENT[1];                   // [RULE6]
    evt[CH_SER0 + 3]         = SERIAL_RX_EVENT[1];                   // [RULE6]
    evt[CH_SER2]             = SERIAL_TX_EVENT[2];                   // [RULE6]
    evt[CH_SER2 + 1]         = SERIAL_RX_EVENT[2];                   // [RULE6]
    evt[CH_TMR2]             = TIMER_EVENT[2];                       // [RULE6]
    evt[CH_SDB]              = SDRAM_EVENT[1];                       // [RULE6]
    evt[CH_CONV +: 2]        = HAS_DECODERS ? CONV_EVENT : 2'b00;    // [RULE8]
    evt[CH_TURB +: 2]        = HAS_DECODERS ? TURBO_EVENT : 2'b00;   // [RULE8]
    evt[CH_CRX]              = HAS_CELL_IF & CELL_EVENT[0];          // [RULE9]
    evt[CH_CTX]              = HAS_CELL_IF & CELL_EVENT[1];          // [RULE9]
    evt                      = evt | CHAIN_EVENT;                    // [RULE10]
  end

  // Selector fields unpacked per level
  always_comb begin
    for (int i = 0; i < ERS_LEVELS; i++) begin
      sel[i] = '0;
    end
    sel[4]  = st.sel_low[SEL_F0 +: ERS_SEL_W];                       // [RULE14]
    sel[5]  = st.sel_low[SEL_F1 +: ERS_SEL_W];
    sel[6]  = st.sel_low[SEL_F2 +: ERS_SEL_W];
    sel[7]  = st.sel_low[SEL_F3 +: ERS_SEL_W];
    sel[8]  = st.sel_low[SEL_F4 +: ERS_SEL_W];
    sel[9]  = st.sel_low[SEL_F5 +: ERS_SEL_W];
    sel[10] = st.sel_high[SEL_F0 +: ERS_SEL_W];
    sel[11] = st.sel_high[SEL_F1 +: ERS_SEL_W];
    sel[12] = st.sel_high[SEL_F2 +: ERS_SEL_W];
    sel[13] = st.sel_high[SEL_F3 +: ERS_SEL_W];
    sel[14] = st.sel_high[SEL_F4 +: ERS_SEL_W];
    sel[15] = st.sel_high[SEL_F5 +: ERS_SEL_W];
  end

  // Level sources: fixed for 0-3, selected for 4-15
  always_comb begin
    lvl_src = '0;
    lvl_src[3:0] = FIXED_IRQ;                                        // [RULE12]
    for (int i = ERS_FIRST_MASK; i < ERS_LEVELS; i++) begin
      lvl_src[i] = IRQ_SOURCE[sel[i]];                               // [RULE13]
    end
  end

  assign wr_acc = PSEL & PENABLE & PWRITE & CE;
  assign rd_acc = PSEL & PENABLE & ~PWRITE & CE;

  // Next-state logic: capture, service, bus access
  always_comb begin
    next_st = st;
    // Pending latches regardless of enable; set beats clear
    next_st.pend = (st.pend & ~DMA_SERVICED) | evt;                  // [RULE2] [RULE16]
    next_st.cpu_pend = (st.cpu_pend & ~CPU_ACK) | lvl_src;
    if (|(evt & ~st.en)) begin
      next_st.irq_stat[IRQ_NEW_EVT] = 1'b1;
    end
    if (|(evt & st.pend & ~DMA_SERVICED)) begin
      next_st.irq_stat[IRQ_ENG_OVR] = 1'b1;
    end
    next_st.slverr = 1'b0;
    case (st.bus)
      ERS_IDLE: begin
        if (PSEL & ~PENABLE) begin
          next_st.bus = ERS_ACCESS;
        end
      end
      ERS_ACCESS: begin
        next_st.bus = ERS_IDLE;
      end
      default: next_st.bus = ERS_IDLE;
    endcase
    // Reads prepared during setup so data is registered in access phase
    if (PSEL & ~PENABLE & ~PWRITE) begin
      case (PADDR)
        ADDR_SEL_HIGH:  next_st.rdata = st.sel_high;
        ADDR_SEL_LOW:   next_st.rdata = st.sel_low;
        ADDR_PEND_LOW:  next_st.rdata = st.pend[31:0];
        ADDR_PEND_HIGH: next_st.rdata = st.pend[63:32];
        ADDR_EN_LOW:    next_st.rdata = st.en[31:0];
        ADDR_EN_HIGH:   next_st.rdata = st.en[63:32];
        ADDR_IRQ_STAT:  next_st.rdata = {30'h0000_0000, st.irq_stat};
        ADDR_IRQ_MASK:  next_st.rdata = {30'h0000_0000, st.irq_mask};
        ADDR_CPU_EN:    next_st.rdata = {16'h0000, st.cpu_en};
        ADDR_CPU_PEND:  next_st.rdata = {16'h0000, st.cpu_pend};
        default:        next_st.rdata = ZERO32;
      endcase
    end
    if ((PSEL & ~PENABLE) && !(PADDR inside {ADDR_SEL_HIGH, ADDR_SEL_LOW, ADDR_PEND_LOW,
        ADDR_PEND_HIGH, ADDR_EN_LOW, ADDR_EN_HIGH, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
        ADDR_CPU_EN, ADDR_CPU_PEND})) begin
      next_st.slverr = 1'b1;
    end
    // Read of status clears it, but a same-cycle event wins
    if (rd_acc && PADDR == ADDR_IRQ_STAT) begin
      next_st.irq_stat = '0;
      if (|(evt & ~st.en)) begin
        next_st.irq_stat[IRQ_NEW_EVT] = 1'b1;
      end
      if (|(evt & st.pend & ~DMA_SERVICED)) begin
        next_st.irq_stat[IRQ_ENG_OVR] = 1'b1;
      end
    end
    if (wr_acc) begin
      case (PADDR)
        ADDR_SEL_HIGH:  next_st.sel_high = PWDATA;                   // [RULE13]
        ADDR_SEL_LOW:   next_st.sel_low  = PWDATA;                   // [RULE13]
        // Write one to clear pending; new events still win
        ADDR_PEND_LOW:  next_st.pend[31:0]  = (st.pend[31:0] & ~DMA_SERVICED[31:0] & ~PWDATA)
                                              | evt[31:0];           // [RULE16]
        ADDR_PEND_HIGH: next_st.pend[63:32] = (st.pend[63:32] & ~DMA_SERVICED[63:32] & ~PWDATA)
                                              | evt[63:32];          // [RULE16]
        ADDR_EN_LOW:    next_st.en[31:0]  = PWDATA;
        ADDR_EN_HIGH:   next_st.en[63:32] = PWDATA;
        ADDR_IRQ_MASK:  next_st.irq_mask  = PWDATA[IRQ_W-1:0];
        ADDR_CPU_EN:    next_st.cpu_en    = PWDATA[15:0];
        default: ;
      endcase
    end
    // Reserved selector bits always read zero
    next_st.sel_high[15] = 1'b0;
    next_st.sel_high[31] = 1'b0;
    next_st.sel_low[15]  = 1'b0;
    next_st.sel_low[31]  = 1'b0;
  end

  // State register with clock enable and synchronous reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st          <= '0;
      st.sel_high <= SEL_HIGH_RST;                                   // [RULE14]
      st.sel_low  <= SEL_LOW_RST;                                    // [RULE14]
      st.cpu_en   <= 16'h000F;
      st.bus      <= ERS_IDLE;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // Interrupt levels: 0-3 always pass, 4-15 gated by enable
  always_comb begin
    CPU_IRQ = st.cpu_pend & (st.cpu_en | 16'h000F);                  // [RULE11] [RULE12]
    CPU_IRQ_VALID = |CPU_IRQ;
    CPU_IRQ_LEVEL = 4'h0;
    for (int i = ERS_LEVELS - 1; i >= 0; i--) begin
      if (CPU_IRQ[i]) begin
        CPU_IRQ_LEVEL = 4'(i);                                       // [RULE17]
      end
    end
  end

  // DMA requests only for enabled channels; priority lives in engine parameters
  assign DMA_REQUEST = st.pend & st.en;                              // [RULE1] [RULE3]
  assign PRDATA      = st.rdata;
  assign PREADY      = (st.bus == ERS_ACCESS);
  assign PSLVERR     = st.slverr & PREADY;
  assign IRQ         = |(st.irq_stat & st.irq_mask);
endmodule
`default_nettype wire
